// ---- dram_access_sequencer.sv ----
// dram access sequencer: state machine, strobes and avalon registers
//
// Contract
// - map field selects dram areas, shared row strobes
// - row phase shifts address by column width
// - a20 not multiplexed in 1-mbyte mode
// - width bit picks 8-bit or 16-bit space
// - cas select routes strobes to port or writes
// - write enable on read pin, low on writes
// - refresh indicator low during refresh cycles
// - access is precharge, row, two column states
// - state control only gates column waits
// - idle state after dram before normal access when cas select routes strobes to writes
// - one precharge state, two when extended
// - row wait state when row wait bit set
// - zero to three column waits from counts
// - refresh ignores waits; wait pin never extends
// - 16-bit uses both strobes, 8-bit upper only
// - all 8-bit with port strobes frees line5
// - same-row bursts repeat only column states
// - compared row bits follow widths
// - compare ranges per column width, 16-bit
//
// Added by the designer: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/100ps
module dram_access_sequencer
	import dram_seq_pkg::*;
(
	input  wire logic               ref_clk,         // system clock
	input  wire logic               rst_n,           // sync reset
	input  wire logic [4:0]         avs_address,     // register byte addr
	input  wire logic               avs_read,        // register read
	input  wire logic               avs_write,       // register write
	input  wire logic [31:0]        avs_writedata,   // write data
	input  wire logic [3:0]         avs_byteenable,  // byte lanes
	output logic      [31:0]        avs_readdata,    // read data
	output logic                    avs_waitrequest, // stall
	input  wire dram_seq_pkg::req_s req,             // access request
	input  wire logic               mode_1mb,        // 1-mbyte mode
	input  wire logic               refresh_req,     // refresh request
	output logic                    req_taken,       // request taken
	output logic                    normal_go,       // non-dram may run
	output logic                    access_done,     // dram access end
	output logic                    refresh_ack,     // refresh end
	output dram_seq_pkg::dram_pins_s pins            // dram pins
);
	import dram_seq_pkg::*;

	state_e      state;
	state_e      next_state;
	logic [7:0]  ctrl_a;
	logic [7:0]  ctrl_b;
	logic [7:0]  abw;
	logic [7:0]  ast;
	logic [7:0]  wch;
	logic [7:0]  wcl;
	logic        pre_done;
	logic [1:0]  wcnt;
	logic        last_dram;
	logic [23:0] cur_addr;
	logic        cur_write;
	logic        cur_word;
	logic [2:0]  cur_area;
	logic        cur_bus8;
	logic [1:0]  cur_wait;
	logic [23:0] cur_key;
	logic [12:0] cur_row;
	logic [1:0]  cur_pin;
	logic [12:0] req_row;
	logic [23:0] req_key;
	dram_pins_s  next_pins;

	// control fields
	wire [2:0] map_field = ctrl_a[CA_MAP_LSB +: 3];
	wire       burst_en  = ctrl_a[CA_BURST];
	wire       refresh_indicator_en   = ctrl_a[CA_REFRESH_INDICATOR_EN];
	wire [1:0] colw      = ctrl_b[CB_COLW_LSB +: 2];
	wire       cas_sel   = ctrl_b[CB_CAS_SEL];
	wire       pre_ext   = ctrl_b[CB_PRE_EXT];
	wire       row_column_wait_bit       = ctrl_b[CB_RCW];
	wire [3:0] dram_mask = map_dram(map_field);
	wire [3:0] ras_used  = map_used(map_field);

	// request decode
	wire [2:0] rel      = req.area - AREA_FIRST;
	wire [1:0] idx      = rel[1:0];
	wire       in_range = (req.area >= AREA_FIRST) && (req.area <= AREA_LAST);
	wire       req_dram = in_range && dram_mask[idx];
	wire       req_bus8 = abw[req.area];
	wire [7:0] wait_all = {wch[3:0], wcl[7:4]};
	wire [1:0] req_wait = ast[req.area] ? wait_all[{idx, 1'b0} +: 2] : 2'h0;
	wire [1:0] req_pin  = map_pin(map_field, idx);
	wire       all_bus8 = &(abw[5:2] | ~dram_mask);

	// sequencing decisions; a request whose answer stands is not retaken
	wire req_new   = req.valid && !req_taken;
	wire refresh_indicator_go   = refresh_req && (map_field != 3'h0) && !refresh_ack;
	wire need_gap  = last_dram && cas_sel;
	wire burst_hit = (state == ST_COL2) && burst_en && req.valid && req_dram &&
		(req.area == cur_area) && (req_key == cur_key) && !refresh_req;
	wire idle_take = (state == ST_IDLE) && req_new && !refresh_indicator_go &&
		(req_dram || !need_gap);
	wire accept    = idle_take || (state == ST_GAP) || burst_hit;
	wire take_dram = accept && req_dram;
	wire in_access = (state == ST_ROW) || (state == ST_ROWW) ||
		(state == ST_COL1) || (state == ST_CWAIT) || (state == ST_COL2);
	wire in_col    = (state == ST_COL1) || (state == ST_CWAIT) ||
		(state == ST_COL2);
	wire in_refresh_indicator   = (state == ST_RPRE) || (state == ST_RR1) ||
		(state == ST_RR2);
	wire pre_more  = pre_ext && !pre_done;

	// row address and compare key of the incoming request
	dram_addr_mux u_mux (
		.addr     (req.addr),
		.colw     (colw),
		.bus8     (req_bus8),
		.mode_1mb (mode_1mb),
		.row      (req_row),
		.key      (req_key)
	);

	// avalon slave: one wait cycle, unmapped reads zero
	wire bus_req  = avs_read || avs_write;
	wire do_write = avs_write && !avs_waitrequest && avs_byteenable[0];
	wire [7:0] wd = avs_writedata[7:0];
	wire map_ok   = (map_field == 3'h0) || (wd[2:0] == 3'h0) ||
		(wd[2:0] == map_field);
	wire [7:0] status = {3'h0, in_access || in_refresh_indicator, state};
	wire [7:0] rd_val =
		(avs_address == OFF_CTRL_A) ? ctrl_a :
		(avs_address == OFF_CTRL_B) ? ctrl_b :
		(avs_address == OFF_ABW)    ? abw :
		(avs_address == OFF_AST)    ? ast :
		(avs_address == OFF_WCH)    ? wch :
		(avs_address == OFF_WCL)    ? wcl :
		(avs_address == OFF_STATUS) ? status : 8'h00;

	// bus handshake and read data
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end else begin
			avs_waitrequest <= !(bus_req && avs_waitrequest);
			if (avs_read && avs_waitrequest)
				avs_readdata <= {24'h00_0000, rd_val};
		end
	end

	// control registers
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ctrl_a <= RST_CTRL;
			ctrl_b <= RST_CTRL;
			abw    <= RST_ABW;
			ast    <= RST_AST;
			wch    <= RST_WC;
			wcl    <= RST_WC;
		end else if (do_write) begin
			if (avs_address == OFF_CTRL_A)
				ctrl_a <= map_ok ? wd : {wd[7:3], map_field};
			if (avs_address == OFF_CTRL_B)
				ctrl_b <= wd;
			if (avs_address == OFF_ABW)
				abw <= wd;
			if (avs_address == OFF_AST)
				ast <= wd;
			if (avs_address == OFF_WCH)
				wch <= wd;
			if (avs_address == OFF_WCL)
				wcl <= wd;
		end
	end

	// next state; the external wait pin is not looked at here
	always_comb begin
		next_state = ST_IDLE;
		unique case (state)
			ST_IDLE: begin
				if (refresh_indicator_go)
					next_state = ST_RPRE;
				else if (req_new && req_dram)
					next_state = ST_PRE;
				else if (req_new && need_gap)
					next_state = ST_GAP;
				else
					next_state = ST_IDLE;
			end
			ST_PRE:   next_state = pre_more ? ST_PRE : ST_ROW;
			ST_ROW:   next_state = row_column_wait_bit ? ST_ROWW : ST_COL1;
			ST_ROWW:  next_state = ST_COL1;
			ST_COL1: begin
				next_state = (cur_wait != 2'h0) ? ST_CWAIT : ST_COL2;
			end
			ST_CWAIT: begin
				next_state = (wcnt == WAIT_ONE) ? ST_COL2 : ST_CWAIT;
			end
			ST_COL2:  next_state = burst_hit ? ST_COL1 : ST_IDLE;
			ST_GAP:   next_state = ST_IDLE;
			ST_RPRE:  next_state = pre_more ? ST_RPRE : ST_RR1;
			ST_RR1:   next_state = ST_RR2;
			ST_RR2:   next_state = ST_IDLE;
			default:  next_state = ST_IDLE;
		endcase
	end

	// state, precharge flag and column wait counter
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state    <= ST_IDLE;
			pre_done <= 1'b0;
			wcnt     <= 2'h0;
		end else begin
			state    <= next_state;
			pre_done <= (state == ST_PRE) || (state == ST_RPRE);
			if (state == ST_COL1)
				wcnt <= cur_wait;
			else if (state == ST_CWAIT)
				wcnt <= wcnt - WAIT_ONE;
		end
	end

	// latch the taken dram access
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cur_addr  <= 24'h00_0000;
			cur_write <= 1'b0;
			cur_word  <= 1'b0;
			cur_area  <= 3'h0;
			cur_bus8  <= 1'b0;
			cur_wait  <= 2'h0;
			cur_key   <= 24'h00_0000;
			cur_row   <= 13'h0000;
			cur_pin   <= 2'h0;
		end else if (take_dram) begin
			cur_addr  <= req.addr;
			cur_write <= req.write;
			cur_word  <= req.word;
			cur_area  <= req.area;
			cur_bus8  <= req_bus8;
			cur_wait  <= req_wait;
			cur_key   <= req_key;
			cur_row   <= req_row;
			cur_pin   <= req_pin;
		end
	end

	// remembers a finished dram cycle for the idle state
	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			last_dram <= 1'b0;
		else if ((state == ST_COL2) && !burst_hit)
			last_dram <= 1'b1;
		else if ((accept && !req_dram) || (state == ST_RPRE))
			last_dram <= 1'b0;
	end

	// column strobes per data half
	wire upper_col_strobe_on = (in_col && (cur_bus8 || cur_word || !cur_addr[0])) ||
		(state == ST_RR1) || (state == ST_RR2);
	wire lower_col_strobe_on = (in_col && !cur_bus8 && (cur_word || cur_addr[0])) ||
		(((state == ST_RR1) || (state == ST_RR2)) && !all_bus8);
	wire [3:0] ras_acc = in_access ? (4'h1 << cur_pin) : 4'h0;
	wire [3:0] ras_ref = (state == ST_RR2) ? ras_used : 4'h0;

	// pin values for the next cycle
	always_comb begin
		next_pins.ras_n  = ~(ras_acc | ras_ref);
		next_pins.pb4_n  = !(upper_col_strobe_on && !cas_sel);
		next_pins.pb5_n  = !(lower_col_strobe_on && !cas_sel);
		next_pins.pb4_en = !cas_sel && (map_field != 3'h0);
		next_pins.pb5_en = !cas_sel && (map_field != 3'h0) && !all_bus8;
		next_pins.hwr_n  = !(upper_col_strobe_on && cas_sel);
		next_pins.lwr_n  = !(lower_col_strobe_on && cas_sel);
		next_pins.we_n   = !(in_access && cur_write);
		next_pins.refresh_indicator_n = !(in_refresh_indicator && refresh_indicator_en);
		next_pins.addr   = in_col ? cur_addr[12:0] : cur_row;
	end

	// registered outputs
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pins        <= '{ras_n: 4'hF, addr: 13'h0000, pb4_en: 1'b0,
				pb5_en: 1'b0, default: 1'b1};
			req_taken   <= 1'b0;
			normal_go   <= 1'b0;
			access_done <= 1'b0;
			refresh_ack <= 1'b0;
		end else begin
			pins        <= next_pins;
			req_taken   <= accept;
			normal_go   <= accept && !req_dram;
			access_done <= (state == ST_COL2);
			refresh_ack <= (state == ST_RR2);
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence s_cols_plain;
		(state == ST_COL1) ##1 (state == ST_COL2);
	endsequence
	sequence s_refresh_tail;
		(state == ST_RR1) ##1 (state == ST_RR2) ##1 (state == ST_IDLE);
	endsequence

	a_row_addr_shift: assert property ((state == ST_ROW) &&
		(colw == 2'h0) |=> pins.addr[11:0] == $past(cur_addr[19:8]))
		else $error("row lines not shifted by eight");
	a_a20_held: assert property ((state == ST_ROW) && mode_1mb &&
		(colw == 2'h0) |=> pins.addr[12] == $past(cur_addr[12]))
		else $error("a20 multiplexed in 1-mbyte mode");
	a_narrow_lower: assert property ((state == ST_COL1) &&
		cur_bus8 |=> pins.pb5_n && pins.lwr_n)
		else $error("lower strobe in 8-bit space");
	a_port_route: assert property (!cas_sel && $past(!cas_sel)
		|-> pins.hwr_n && pins.lwr_n)
		else $error("write pins strobed with port routing");
	a_we_read: assert property ((state == ST_COL1) && !cur_write
		|=> pins.we_n)
		else $error("write enable low in a read");
	a_refresh_indicator_low: assert property ((state == ST_RR1) && refresh_indicator_en
		|=> !pins.refresh_indicator_n ##1 !pins.refresh_indicator_n)
		else $error("refresh indicator not low");
	a_basic_four: assert property ((state == ST_PRE) && !pre_ext &&
		!row_column_wait_bit && (cur_wait == 2'h0) |=> (state == ST_ROW) ##1 s_cols_plain)
		else $error("basic access not four states");
	a_no_wait: assert property ((state == ST_COL1) &&
		(cur_wait == 2'h0) |=> state == ST_COL2)
		else $error("wait inserted with waits off");
	a_gap_go: assert property ((state == ST_GAP) |=>
		req_taken && normal_go)
		else $error("idle state not followed by normal access");
	a_one_take: assert property (req_taken |=> !req_taken)
		else $error("one request taken twice");
	a_pre_two: assert property ((state == ST_PRE) && !pre_done &&
		pre_ext |=> (state == ST_PRE) ##1 (state == ST_ROW))
		else $error("extended precharge not two states");
	a_row_wait: assert property ((state == ST_ROW) && row_column_wait_bit
		|=> (state == ST_ROWW) ##1 (state == ST_COL1))
		else $error("row wait state missing");
	a_three_waits: assert property ((state == ST_COL1) &&
		(cur_wait == 2'h3) |=> (state == ST_CWAIT)[*3] ##1 state == ST_COL2)
		else $error("column waits not three");
	a_refresh_indicator_fixed: assert property ((state == ST_RPRE) && !pre_more
		|=> s_refresh_tail)
		else $error("refresh cycle stretched");
	a_burst_cols: assert property (burst_hit
		|=> (state == ST_COL1) && pins.ras_n == $past(pins.ras_n))
		else $error("burst did not resume at column state");
	a_even_byte: assert property ((state == ST_COL1) && !cur_bus8 &&
		!cur_word && !cur_addr[0] && !cas_sel |=> !pins.pb4_n && pins.pb5_n)
		else $error("even byte strobes wrong");
	a_ras_row: assert property ((state == ST_ROW)
		|=> pins.ras_n[cur_pin] == 1'b0)
		else $error("row strobe not asserted in row state");
endmodule

// ---- dram_access_sequencer_bench.sv ----
// self-checking bench for the dram access sequencer
`timescale 1ns/100ps
module dram_access_sequencer_bench import dram_seq_pkg::*;;
	logic        ref_clk, rst_n, avs_read, avs_write, avs_waitrequest;
	logic [4:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic        mode_1mb, refresh_req, req_taken, normal_go;
	logic        access_done, refresh_ack, cas_pin_select, clr, last_ng;
	req_s        req;
	dram_pins_s  pins;
	logic [12:0] row, col;
	logic [3:0]  ras_seen;
	logic [7:0]  ras_falls;
	logic [4:0]  low_seen;
	int          n_errors, tests_run, last_k, n;

	dram_access_sequencer DUT (.ref_clk(ref_clk), .rst_n(rst_n),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .req(req), .mode_1mb(mode_1mb),
		.refresh_req(refresh_req), .req_taken(req_taken),
		.normal_go(normal_go), .access_done(access_done),
		.refresh_ack(refresh_ack), .pins(pins));
	dram_model chip (.pins(pins), .cas_pin_select(cas_pin_select), .clr(clr), .row(row),
		.col(col), .ras_seen(ras_seen), .ras_falls(ras_falls),
		.low_seen(low_seen));

	// clock and watchdog
	always #2.5 ref_clk = ~ref_clk;
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_errors++;
		test_done;
	end

	// verdict and end of run
	task test_done;
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// one comparison
	task automatic chk(input string nm, input logic [31:0] e,
			input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one avalon transfer, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [4:0] a,
			input logic [7:0] d, output logic [31:0] q);
		int k;
		k = 0;
		@(posedge ref_clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {24'h0, d};
		do begin
			@(posedge ref_clk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 50);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (k >= 50)
			chk("waitrequest", 0, 1);
	endtask

	// register write and checked read
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input string nm, input logic [4:0] a,
			input logic [7:0] e);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, q);
		chk(nm, {24'h0, e}, q);
	endtask

	// present a request and hold it until taken
	task automatic go(input logic [23:0] a, input logic [2:0] ar,
			input logic w, input logic wd);
		int k;
		k = 0;
		@(posedge ref_clk);
		req <= '{1'b1, a, w, wd, ar};
		do begin
			@(posedge ref_clk);
			k++;
		end while (req_taken !== 1'b1 && k < 60);
		last_k = k;
		last_ng = normal_go;
		req.valid <= 1'b0;
		if (k >= 60)
			chk("req_taken", 1, 0);
	endtask

	// count cycles to access end, refresh, clear records
	task automatic wdone;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (access_done !== 1'b1 && n < 60);
	endtask
	task automatic rf;
		clr <= 1'b1;
		@(posedge ref_clk);
		clr <= 1'b0;
		refresh_req <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (refresh_ack !== 1'b1 && n < 60);
		refresh_req <= 1'b0;
	endtask
	task automatic clean;
		clr <= 1'b1;
		@(posedge ref_clk);
		clr <= 1'b0;
	endtask

	// reset values and unmapped offset
	task automatic t_regs;
		rd("ctrl_a", OFF_CTRL_A, RST_CTRL);
		rd("ctrl_b", OFF_CTRL_B, RST_CTRL);
		rd("width", OFF_ABW, RST_ABW);
		rd("state", OFF_AST, RST_AST);
		rd("wait_hi", OFF_WCH, RST_WC);
		rd("wait_lo", OFF_WCL, RST_WC);
		rd("unmapped", 5'h1C, 8'h00);
		wr(OFF_WCH, 8'h5A);
		rd("wait_hi", OFF_WCH, 8'h5A);
	endtask

	// shared row strobe, then normal space
	task automatic t_map;
		wr(OFF_ABW, 8'h00);
		wr(OFF_AST, 8'h00);
		wr(OFF_CTRL_A, 8'h03); // row hold kept clear
		clean;
		go(24'h000010, 3'h3, 1'b0, 1'b1);
		wdone;
		chk("shared ras", 4'h1, ras_seen);
		wr(OFF_CTRL_A, 8'h00);
		wr(OFF_CTRL_A, 8'h01);
		go(24'h000010, 3'h3, 1'b0, 1'b1);
		chk("normal_go", 1'b1, last_ng);
		wr(OFF_CTRL_A, 8'h00);
		wr(OFF_CTRL_A, 8'h05);
	endtask

	// state count and address multiplexing per column width
	task automatic t_basic;
		logic [23:0] a;
		logic [12:0] r;
		a = 24'hC3A55A;
		for (int w = 0; w < 3; w++) begin
			wr(OFF_CTRL_B, 8'(w));
			clean;
			go(a, 3'h2, 1'b0, 1'b1);
			wdone;
			chk("states", 4, n);
			r = 13'(a >> (8 + w));
			for (int j = 13 - w; j < 13; j++)
				r[j] = a[j];
			chk("row", r, row);
			chk("col", a[12:0], col);
			chk("strobes", 5'h18, low_seen);
		end
		mode_1mb <= 1'b1;
		clean;
		go(24'h100000, 3'h2, 1'b0, 1'b1);
		wdone;
		chk("row a20", 13'h0000, row);
		mode_1mb <= 1'b0;
	endtask

	// column strobe selection for one access
	task automatic st(input logic [7:0] abw, input logic cs,
			input logic [23:0] a, input logic w, input logic wd,
			input logic [4:0] e);
		wr(OFF_ABW, abw);
		wr(OFF_CTRL_B, {5'h0, cs, 2'h0});
		cas_pin_select <= cs;
		clean;
		go(a, 3'h2, w, wd);
		wdone;
		chk("strobes", e, low_seen);
	endtask

	// wait settings against access length
	task automatic wt(input logic [7:0] cb, input logic [7:0] ast,
			input logic [7:0] wcl, input int e);
		wr(OFF_CTRL_B, cb);
		wr(OFF_AST, ast);
		wr(OFF_WCL, wcl);
		go(24'h000020, 3'h2, 1'b0, 1'b1);
		wdone;
		chk("wait len", e, n);
	endtask

	// two accesses, the second possibly in the same page
	task automatic pair(input logic [23:0] b, input int e,
			input logic [7:0] f);
		clean;
		go(24'h000000, 3'h2, 1'b0, 1'b0);
		go(b, 3'h2, 1'b0, 1'b0);
		wdone;
		chk("burst len", e, n);
		chk("ras falls", f, ras_falls);
	endtask

	// refresh indicator and refresh length
	task automatic t_refresh;
		int r0;
		wr(OFF_CTRL_A, 8'h25);
		wr(OFF_CTRL_B, 8'h00);
		rf;
		r0 = n;
		chk("refresh low", 1'b1, low_seen[0]);
		repeat (2) @(posedge ref_clk);
		chk("refresh idle", 1'b1, pins.refresh_indicator_n);
		wr(OFF_CTRL_B, 8'h18);
		wr(OFF_AST, 8'h04);
		rf;
		chk("refresh len", r0 + 1, n);
		wr(OFF_CTRL_A, 8'h05);
		wr(OFF_CTRL_B, 8'h00);
		wr(OFF_AST, 8'h00);
	endtask

	// normal access right after dram, both strobe pin choices
	task automatic t_gap;
		int k0;
		for (int c = 0; c < 2; c++) begin
			wr(OFF_CTRL_B, {5'h0, c[0], 2'h0});
			cas_pin_select <= c[0];
			go(24'h000000, 3'h2, 1'b0, 1'b1);
			go(24'h000000, 3'h6, 1'b0, 1'b1);
			if (c == 0)
				k0 = last_k;
		end
		chk("idle gap", k0 + 1, last_k);
		chk("normal_go", 1'b1, last_ng);
	endtask

	// main sequence
	initial begin
		ref_clk = 1'b0;
		rst_n = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 5'h00;
		avs_writedata = 32'h0;
		req = '0;
		mode_1mb = 1'b0;
		refresh_req = 1'b0;
		cas_pin_select = 1'b0;
		clr = 1'b1;
		n_errors = 0;
		tests_run = 0;
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		clr <= 1'b0;
		t_regs;
		t_map;
		t_basic;
		st(8'h00, 1'b0, 24'h000100, 1'b1, 1'b0, 5'h12);
		st(8'h00, 1'b0, 24'h000101, 1'b1, 1'b0, 5'h0A);
		st(8'h00, 1'b1, 24'h000102, 1'b1, 1'b1, 5'h1A);
		st(8'hFF, 1'b0, 24'h000103, 1'b0, 1'b0, 5'h10);
		chk("line5 free", 1'b0, pins.pb5_en);
		chk("line4 used", 1'b1, pins.pb4_en);
		wr(OFF_ABW, 8'h00);
		wt(8'h18, 8'h04, 8'hFF, 9);
		wt(8'h18, 8'h04, 8'hEF, 8);
		wt(8'h00, 8'h04, 8'hCF, 4);
		wt(8'h08, 8'h00, 8'hFF, 5);
		wt(8'h10, 8'h00, 8'hFF, 5);
		t_refresh;
		wr(OFF_CTRL_A, 8'h0D);
		pair(24'h000100, 2, 8'h01);
		pair(24'h000200, 4, 8'h02);
		wr(OFF_ABW, 8'hFF);
		pair(24'h000100, 4, 8'h02);
		wr(OFF_ABW, 8'h00);
		wr(OFF_CTRL_A, 8'h05);
		t_gap;
		test_done;
	end
endmodule

// ---- dram_addr_mux.sv ----
// row address multiplexer and burst row compare key
`timescale 1ns/100ps
module dram_addr_mux
	import dram_seq_pkg::*;
(
	input  wire logic [23:0] addr,     // full access address
	input  wire logic [1:0]  colw,     // column width select
	input  wire logic        bus8,     // area is 8-bit space
	input  wire logic        mode_1mb, // 1-mbyte operating mode
	output logic      [12:0] row,      // row phase address lines
	output logic      [23:0] key       // masked row compare value
);
	// illegal width falls back to ten column bits
	wire [1:0] shift = (colw == COLW_ILLEGAL) ? COLW_10BIT : colw;
	wire [4:0] lo    = 5'(CMP_BASE) + {3'h0, shift} - {4'h0, bus8};
	wire [4:0] top   = mode_1mb ? 5'(CMP_TOP_1MB) : 5'(CMP_TOP_16MB);

	// per line: row bit shifted down, a20 held back in 1-mbyte mode
	for (genvar i = 0; i < 13; i++) begin : g_row
		wire [2:0] cand;
		for (genvar k = 0; k < 3; k++) begin : g_k
			localparam int S = i + ROW_BASE + k;
			assign cand[k] = (S > ROW_A20) ? addr[i] :
				((S == ROW_A20) && mode_1mb) ? addr[i] : addr[S];
		end
		assign row[i] = cand[shift];
	end

	// compare range depends on column width and bus width
	for (genvar b = 0; b < 24; b++) begin : g_key
		assign key[b] = (5'(b) >= lo) && (5'(b) <= top) && addr[b];
	end
endmodule

// ---- dram_model.sv ----
// dram chip model that records what it sees on the sequencer pins
`timescale 1ns/100ps
module dram_model
	import dram_seq_pkg::*;
(
	input  wire dram_seq_pkg::dram_pins_s pins,      // sequencer pins
	input  wire logic                     cas_pin_select,      // strobes on write pins
	input  wire logic                     clr,       // clear the records
	output logic                   [12:0] row,       // row at ras fall
	output logic                   [12:0] col,       // column at cas fall
	output logic                   [3:0]  ras_seen,  // row strobes seen low
	output logic                   [7:0]  ras_falls, // row strobe falls
	output logic                   [4:0]  low_seen   // u, l, bad, we, refresh_indicator
);
	logic ras_n;
	logic u_n;
	logic l_n;
	logic bad;
	logic p_ras = 1'b1;
	logic p_cas = 1'b1;
	// unused port lines are ignored, strobes follow the board strap
	always @(pins or clr or cas_pin_select) begin
		ras_n = &pins.ras_n;
		u_n = cas_pin_select ? pins.hwr_n : (pins.pb4_n | !pins.pb4_en);
		l_n = cas_pin_select ? pins.lwr_n : (pins.pb5_n | !pins.pb5_en);
		bad = cas_pin_select ? (pins.pb4_en | pins.pb5_en) : !(pins.hwr_n & pins.lwr_n);
		if (clr) begin
			ras_seen = 4'h0;
			ras_falls = 8'h00;
			low_seen = 5'h00;
		end else begin
			if (!ras_n && p_ras) begin
				row = pins.addr;
				ras_falls = ras_falls + 8'h01;
			end
			if (!(u_n & l_n) && p_cas)
				col = pins.addr;
			ras_seen = ras_seen | ~pins.ras_n;
			low_seen = low_seen | {!u_n, !l_n, bad, !pins.we_n, !pins.refresh_indicator_n};
		end
		p_ras = ras_n;
		p_cas = u_n & l_n;
	end
endmodule

// ---- dram_seq_pkg.sv ----
// shared constants and types for the dram access sequencer
package dram_seq_pkg;
	// register byte offsets on the avalon slave
	localparam logic [4:0] OFF_CTRL_A = 5'h00;
	localparam logic [4:0] OFF_CTRL_B = 5'h04;
	localparam logic [4:0] OFF_ABW    = 5'h08;
	localparam logic [4:0] OFF_AST    = 5'h0C;
	localparam logic [4:0] OFF_WCH    = 5'h10;
	localparam logic [4:0] OFF_WCL    = 5'h14;
	localparam logic [4:0] OFF_STATUS = 5'h18;
	// field positions in dram_control_a
	localparam int CA_MAP_LSB = 0;
	localparam int CA_BURST   = 3;
	localparam int CA_ROWHOLD = 4;
	localparam int CA_REFRESH_INDICATOR_EN = 5;
	// field positions in dram_control_b
	localparam int CB_COLW_LSB = 0;
	localparam int CB_CAS_SEL  = 2;
	localparam int CB_PRE_EXT  = 3;
	localparam int CB_RCW      = 4;
	// reset values
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] RST_ABW  = 8'hFF;
	localparam logic [7:0] RST_AST  = 8'hFF;
	localparam logic [7:0] RST_WC   = 8'hFF;
	// address multiplexing figures
	localparam int ROW_BASE     = 8;
	localparam int ROW_A20      = 20;
	localparam int CMP_BASE     = 9;
	localparam int CMP_TOP_1MB  = 19;
	localparam int CMP_TOP_16MB = 23;
	localparam logic [1:0] COLW_ILLEGAL = 2'h3;
	localparam logic [1:0] COLW_10BIT   = 2'h2;
	localparam logic [2:0] AREA_FIRST   = 3'h2;
	localparam logic [2:0] AREA_LAST    = 3'h5;
	localparam logic [1:0] WAIT_ONE     = 2'h1;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'h0,
		ST_PRE   = 4'h1,
		ST_ROW   = 4'h2,
		ST_ROWW  = 4'h3,
		ST_COL1  = 4'h4,
		ST_CWAIT = 4'h5,
		ST_COL2  = 4'h6,
		ST_GAP   = 4'h7,
		ST_RPRE  = 4'h8,
		ST_RR1   = 4'h9,
		ST_RR2   = 4'hA
	} state_e;

	typedef struct packed {
		logic        valid;
		logic [23:0] addr;
		logic        write;
		logic        word;
		logic [2:0]  area;
	} req_s;

	typedef struct packed {
		logic [3:0]  ras_n;
		logic        pb4_n;
		logic        pb5_n;
		logic        pb4_en;
		logic        pb5_en;
		logic        hwr_n;
		logic        lwr_n;
		logic        we_n;
		logic        refresh_indicator_n;
		logic [12:0] addr;
	} dram_pins_s;

	// areas 2..5 that are dram space, bit 0 is area 2
	function automatic logic [3:0] map_dram(input logic [2:0] m);
		unique case (m)
			3'h0: map_dram = 4'h0;
			3'h1: map_dram = 4'h1;
			3'h2, 3'h3: map_dram = 4'h3;
			3'h4: map_dram = 4'h7;
			default: map_dram = 4'hF;
		endcase
	endfunction

	// row strobe pin serving area k (0 is area 2)
	function automatic logic [1:0] map_pin(input logic [2:0] m,
			input logic [1:0] k);
		unique case (m)
			3'h3, 3'h7: map_pin = 2'h0;
			3'h6: map_pin = {k[1], 1'b0};
			default: map_pin = k;
		endcase
	endfunction

	// row strobe pins in use for a map setting
	function automatic logic [3:0] map_used(input logic [2:0] m);
		unique case (m)
			3'h0: map_used = 4'h0;
			3'h2: map_used = 4'h3;
			3'h4: map_used = 4'h7;
			3'h5: map_used = 4'hF;
			3'h6: map_used = 4'h5;
			default: map_used = 4'h1;
		endcase
	endfunction
endpackage
